/* File: core/pan_pkg.sv */
// Purpose: shared constants of the per-PHY auto-negotiation register bank
// Assumes: 16-bit management words, five-bit register addresses, four PHYs
// Notes: offsets, field positions and reset values live here only
`default_nettype none
package pan_pkg;
  // ==========================================================
  // geometry
  localparam int NUM_PHY = 4;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 5;
  localparam int PHY_W = 2;

  // ==========================================================
  // register offsets
  localparam logic [4:0] OFF_ID_HI = 5'h02;
  localparam logic [4:0] OFF_ID_LO = 5'h03;
  localparam logic [4:0] OFF_ADV = 5'h04;
  localparam logic [4:0] OFF_LPA = 5'h05;
  localparam logic [4:0] OFF_EXP = 5'h06;
  localparam logic [4:0] OFF_NPT = 5'h07;
  localparam logic [4:0] OFF_DEV_ID = 5'h10;

  // ==========================================================
  // advertisement fields
  localparam int ADV_NP_BIT = 15;
  localparam int ADV_RF_BIT = 13;
  localparam int ADV_FD_BIT = 6;
  localparam int ADV_HD_BIT = 5;
  localparam logic [4:0] ADV_SEL_VAL = 5'h01;
  localparam logic ADV_RF_RST = 1'b0;
  localparam logic ADV_FD_RST = 1'b1;
  localparam logic ADV_HD_RST = 1'b1;

  // ==========================================================
  // partner ability fields: bits 14 and 12..10 read as zero on a base page
  localparam logic [15:0] LPA_BASE_MASK = 16'hA3FF;
  localparam int LPA_NP_BIT = 15;

  // ==========================================================
  // expansion fields
  localparam int EXP_PDF_BIT = 4;
  localparam int EXP_LPNP_BIT = 3;
  localparam int EXP_NP_BIT = 2;
  localparam int EXP_PAGE_BIT = 1;
  localparam int EXP_LPAN_BIT = 0;

  // ==========================================================
  // identical consecutive code words needed to accept a page
  localparam logic [1:0] CW_MATCH_CNT = 2'h3;
endpackage : pan_pkg
`default_nettype wire

/* File: core/pan_cw_filter.sv */
// Purpose: accept a link code word once seen identical three times in a row
// Assumes: one word per cw_valid pulse from the negotiation engine
// Notes: the accepted word appears one cycle after the third match
`default_nettype none
module pan_cw_filter (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic cw_valid,
  input wire logic [pan_pkg::DATA_W-1:0] cw_word,
  output logic page_hit,
  output logic [pan_pkg::DATA_W-1:0] page_word
);
  import pan_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] prev;
    logic [1:0] cnt;
    logic hit;
    logic [DATA_W-1:0] word;
  } pan_flt_s;

  pan_flt_s st_reg;
  pan_flt_s st_next;

  // ==========================================================
  // match counter; saturates so a held word is accepted once only
  always_comb begin
    st_next = st_reg;
    st_next.hit = 1'b0;
    if (cw_valid) begin
      if (cw_word == st_reg.prev && st_reg.cnt != 2'h0) begin
        if (st_reg.cnt == CW_MATCH_CNT - 2'h1) begin
          st_next.hit = 1'b1; // R12
          st_next.word = cw_word;
        end
        if (st_reg.cnt != CW_MATCH_CNT) begin
          st_next.cnt = st_reg.cnt + 2'h1;
        end
      end else begin
        st_next.prev = cw_word;
        st_next.cnt = 2'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign page_hit = st_reg.hit;
  assign page_word = st_reg.word;

  // ==========================================================
  // checks
  a_hit_after_three: assert property (@(posedge sys_clk) disable iff (sys_rst) // R12
    page_hit |-> $past(st_reg.cnt) == 2'h2 && $past(cw_valid))
    else $error("page accepted without three identical words");
endmodule : pan_cw_filter
`default_nettype wire

/* File: core/pan_regs.sv */
// Purpose: per-PHY auto-negotiation register bank for a four-port transceiver
// Assumes: management access arrives as single-cycle read and write strobes
// Notes: read data is registered one cycle after the read strobe
`default_nettype none
// Notes on behaviour
// R1: identifier pair reads fixed, ignores writes
// R2: advertisement bit 15 shows queued next page
// R3: remote fault bit set only by management
// R4: only ability bits 6 and 5 writable
// R5: duplex pin probe after reset sets 6/5
// R6: selector field fixed at 00001
// R7: partner ability holds latest word, read-only
// R8: software ignores partner word unless flagged
// R9: base page shows reserved bits as zero
// R10: page flag set means exact next page
// R11: reading partner ability clears page flag
// R12: page flag after three identical words
// R13: parallel fault bit is inverse of link
// R14: expansion bit 3 shows partner next-page ability
// R15: local next-page ability bit reads one
// R16: expansion bit 0 set after fast pulses
// R17: next-page write loads and requests transmit
// R18: device identifier fixed, writes ignored
// R19: negotiation done flag tracks engine completion
// R20: link bit follows valid link pulses
// R21: read-only bits ignore writes, reserved zero
// R22: each PHY keeps independent registers
module pan_regs #(
  parameter logic [15:0] ID_HIGH_VAL = 16'h1357, // arbitrary value
  parameter logic [15:0] ID_LOW_VAL = 16'h2468, // arbitrary value
  parameter logic [15:0] DEV_ID_VAL = 16'h00A5 // arbitrary value
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [pan_pkg::PHY_W-1:0] reg_phy,
  input wire logic [pan_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pan_pkg::DATA_W-1:0] reg_wdata,
  output logic [pan_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [pan_pkg::NUM_PHY-1:0] cw_valid,
  input wire logic [pan_pkg::NUM_PHY-1:0][pan_pkg::DATA_W-1:0] cw_word,
  input wire logic [pan_pkg::NUM_PHY-1:0] flp_seen,
  input wire logic [pan_pkg::NUM_PHY-1:0] link_pulse_ok,
  input wire logic [pan_pkg::NUM_PHY-1:0] an_finished,
  input wire logic [pan_pkg::NUM_PHY-1:0] np_sent,
  output logic [pan_pkg::NUM_PHY-1:0][pan_pkg::DATA_W-1:0] adv_word,
  output logic [pan_pkg::NUM_PHY-1:0][pan_pkg::DATA_W-1:0] np_tx_word,
  output logic [pan_pkg::NUM_PHY-1:0] np_tx_req,
  output logic [pan_pkg::NUM_PHY-1:0] negotiation_done,
  output logic [pan_pkg::NUM_PHY-1:0] link_up,
  input wire logic [pan_pkg::NUM_PHY-1:0] duplex_in,
  output logic [pan_pkg::NUM_PHY-1:0] duplex_out,
  output logic [pan_pkg::NUM_PHY-1:0] duplex_oe
);
  import pan_pkg::*;

  typedef enum logic [1:0] {PROBE_HIGH, PROBE_LOW, PROBE_DONE} pan_probe_e;

  typedef struct packed {
    logic [NUM_PHY-1:0] fault_adv;
    logic [NUM_PHY-1:0] full_adv;
    logic [NUM_PHY-1:0] half_adv;
    logic [NUM_PHY-1:0] next_page_pending;
    logic [NUM_PHY-1:0][DATA_W-1:0] lpa;
    logic [NUM_PHY-1:0][DATA_W-1:0] npt;
    logic [NUM_PHY-1:0] page_received_flag;
    logic [NUM_PHY-1:0] partner_extra_page_capable;
    logic [NUM_PHY-1:0] partner_negotiation_capable;
    logic [NUM_PHY-1:0] link;
    logic [NUM_PHY-1:0] done;
    logic [NUM_PHY-1:0] np_req;
    logic [NUM_PHY-1:0] dup_out;
    logic [NUM_PHY-1:0] dup_oe;
    pan_probe_e [NUM_PHY-1:0] probe;
    logic [DATA_W-1:0] rdata;
  } pan_state_s;

  pan_state_s st_reg;
  pan_state_s st_next;
  logic [NUM_PHY-1:0] page_hit;
  logic [NUM_PHY-1:0][DATA_W-1:0] page_word;

  // ==========================================================
  // advertisement word as seen by software and by the engine
  function automatic logic [DATA_W-1:0] adv_of(input pan_state_s s, input logic [1:0] p);
    logic [DATA_W-1:0] w;
    w = '0; // R21
    w[ADV_NP_BIT] = s.next_page_pending[p]; // R2
    w[ADV_RF_BIT] = s.fault_adv[p]; // R3
    w[ADV_FD_BIT] = s.full_adv[p]; // R4
    w[ADV_HD_BIT] = s.half_adv[p]; // R4
    w[4:0] = ADV_SEL_VAL; // R6
    return w;
  endfunction : adv_of

  // ==========================================================
  // read multiplexer; unmapped offsets read as zero
  function automatic logic [DATA_W-1:0] rd_word(input pan_state_s s, input logic [1:0] p,
                                                input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] w;
    w = '0;
    case (a)
      OFF_ID_HI: w = ID_HIGH_VAL; // R1
      OFF_ID_LO: w = ID_LOW_VAL; // R1
      OFF_ADV: w = adv_of(s, p);
      OFF_LPA: begin
        // while the page flag is set the word is shown raw; once cleared its reserved bits are hidden
        w = s.page_received_flag[p] ? s.lpa[p] : (s.lpa[p] & LPA_BASE_MASK); // R9 R10
      end
      OFF_EXP: begin
        w[EXP_PDF_BIT] = ~s.link[p]; // R13
        w[EXP_LPNP_BIT] = s.partner_extra_page_capable[p]; // R14
        w[EXP_NP_BIT] = 1'b1; // R15
        w[EXP_PAGE_BIT] = s.page_received_flag[p];
        w[EXP_LPAN_BIT] = s.partner_negotiation_capable[p]; // R16
      end
      OFF_NPT: w = s.npt[p];
      OFF_DEV_ID: w = DEV_ID_VAL; // R18
      default: w = '0;
    endcase
    return w;
  endfunction : rd_word

  // ==========================================================
  // one code word filter per port so pages never mix between PHYs
  for (genvar g = 0; g < NUM_PHY; g++) begin : g_flt
    pan_cw_filter u_flt (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .cw_valid(cw_valid[g]),
      .cw_word(cw_word[g]),
      .page_hit(page_hit[g]),
      .page_word(page_word[g])
    ); // R22
  end

  // ==========================================================
  // next state of the whole bank
  always_comb begin
    logic wr_here;
    logic rd_lpa;
    wr_here = 1'b0;
    rd_lpa = 1'b0;
    st_next = st_reg;
    st_next.np_req = '0;
    if (reg_rd) begin
      st_next.rdata = rd_word(st_reg, reg_phy, reg_addr);
    end
    for (int i = 0; i < NUM_PHY; i++) begin
      wr_here = reg_wr && (reg_phy == i[PHY_W-1:0]); // R22
      rd_lpa = reg_rd && (reg_phy == i[PHY_W-1:0]) && (reg_addr == OFF_LPA);
      st_next.link[i] = link_pulse_ok[i]; // R20
      st_next.done[i] = an_finished[i]; // R19
      // only management touches the fault bit; ability bits also take the duplex probe; others stay fixed
      if (wr_here && reg_addr == OFF_ADV) begin
        st_next.fault_adv[i] = reg_wdata[ADV_RF_BIT]; // R3
        st_next.full_adv[i] = reg_wdata[ADV_FD_BIT]; // R4
        st_next.half_adv[i] = reg_wdata[ADV_HD_BIT]; // R4
      end
      // duplex probe: drive high, sample, drive low, sample, release
      case (st_reg.probe[i])
        PROBE_HIGH: begin
          st_next.full_adv[i] = duplex_in[i]; // R5
          st_next.dup_out[i] = 1'b0;
          st_next.probe[i] = PROBE_LOW;
        end
        PROBE_LOW: begin
          st_next.half_adv[i] = ~duplex_in[i]; // R5
          st_next.dup_oe[i] = 1'b0;
          st_next.probe[i] = PROBE_DONE;
        end
        PROBE_DONE: st_next.probe[i] = PROBE_DONE;
        default: st_next.probe[i] = PROBE_DONE;
      endcase
      // pending clears when sent; a new write in the same cycle wins
      if (np_sent[i]) begin
        st_next.next_page_pending[i] = 1'b0;
      end
      if (wr_here && reg_addr == OFF_NPT) begin
        st_next.npt[i] = reg_wdata; // R17
        st_next.np_req[i] = 1'b1; // R17
        st_next.next_page_pending[i] = 1'b1; // R2
      end
      // writes to partner ability are dropped; only accepted pages load it
      if (rd_lpa) begin
        st_next.page_received_flag[i] = 1'b0; // R11
      end
      if (page_hit[i]) begin
        st_next.lpa[i] = page_word[i]; // R7 R10
        st_next.page_received_flag[i] = 1'b1; // R12
        if (page_word[i][LPA_NP_BIT]) begin
          st_next.partner_extra_page_capable[i] = 1'b1; // R14
        end
      end
      if (flp_seen[i]) begin
        st_next.partner_negotiation_capable[i] = 1'b1; // R16
      end
    end
  end

  // ==========================================================
  // state register; probe starts driving high straight out of reset
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '0;
      st_reg.fault_adv <= {NUM_PHY{ADV_RF_RST}};
      st_reg.full_adv <= {NUM_PHY{ADV_FD_RST}};
      st_reg.half_adv <= {NUM_PHY{ADV_HD_RST}};
      st_reg.dup_out <= '1;
      st_reg.dup_oe <= '1;
      for (int i = 0; i < NUM_PHY; i++) begin
        st_reg.probe[i] <= PROBE_HIGH;
      end
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // outputs
  always_comb begin
    for (int i = 0; i < NUM_PHY; i++) begin
      adv_word[i] = adv_of(st_reg, i[1:0]);
    end
  end
  assign reg_rdata = st_reg.rdata;
  assign np_tx_word = st_reg.npt;
  assign np_tx_req = st_reg.np_req;
  assign negotiation_done = st_reg.done;
  assign link_up = st_reg.link;
  assign duplex_out = st_reg.dup_out;
  assign duplex_oe = st_reg.dup_oe;

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  logic link_sel;
  assign link_sel = st_reg.link[reg_phy];

  a_ident_fixed: assert property ( // R1
    reg_rd && reg_addr == OFF_ID_HI |=> reg_rdata == ID_HIGH_VAL)
    else $error("identifier high changed");
  a_adv_fixed_bits: assert property ( // R6
    adv_word[0][4:0] == ADV_SEL_VAL && adv_word[0][14] == 1'b0 && adv_word[0][12:7] == 6'h00)
    else $error("advertisement fixed bits wrong");
  a_pardet_inverse: assert property ( // R13
    reg_rd && reg_addr == OFF_EXP |=> reg_rdata[EXP_PDF_BIT] == ~$past(link_sel)
      && reg_rdata[EXP_NP_BIT])
    else $error("expansion fault or capability bit wrong");
  a_np_request: assert property ( // R17
    reg_wr && reg_addr == OFF_NPT |=> np_tx_req[$past(reg_phy)]
      && np_tx_word[$past(reg_phy)] == $past(reg_wdata)
      ##1 (!np_tx_req[$past(reg_phy, 2)] || ($past(reg_wr) && $past(reg_addr) == OFF_NPT)))
    else $error("next page write did not request one pulse");
  a_np_pending: assert property ( // R2
    reg_wr && reg_addr == OFF_NPT && reg_phy == 2'h1 |=> adv_word[1][ADV_NP_BIT])
    else $error("next page pending not shown");
  a_page_clear: assert property ( // R11
    reg_rd && reg_addr == OFF_LPA && reg_phy == 2'h2 && !page_hit[2]
      |=> !st_reg.page_received_flag[2])
    else $error("partner read did not clear page flag");
  a_page_load: assert property ( // R10
    page_hit[2] |=> st_reg.page_received_flag[2] && st_reg.lpa[2] == $past(page_word[2]))
    else $error("accepted page not captured");
  a_lpa_readonly: assert property ( // R7
    !page_hit[2] |=> $stable(st_reg.lpa[2]))
    else $error("partner ability changed without a page");
  a_lpa_base_mask: assert property ( // R9
    reg_rd && reg_addr == OFF_LPA && !st_reg.page_received_flag[reg_phy]
      |=> reg_rdata[14] == 1'b0 && reg_rdata[12:10] == 3'h0)
    else $error("partner base page shows reserved bits");
  a_partner_np_sticky: assert property ( // R14
    (page_hit[2] && page_word[2][LPA_NP_BIT]) || st_reg.partner_extra_page_capable[2]
      |=> st_reg.partner_extra_page_capable[2])
    else $error("partner next-page ability lost or missed");
  a_flp_sticky: assert property ( // R16
    flp_seen[0] || st_reg.partner_negotiation_capable[0]
      |=> st_reg.partner_negotiation_capable[0])
    else $error("partner negotiation ability lost or missed");
  a_fault_write: assert property ( // R3
    reg_wr && reg_addr == OFF_ADV && reg_phy == 2'h0
      |=> adv_word[0][ADV_RF_BIT] == $past(reg_wdata[ADV_RF_BIT]))
    else $error("remote fault bit not written");
  a_page_flag_set: assert property ( // R12
    $rose(st_reg.page_received_flag[2]) |-> $past(page_hit[2]))
    else $error("page flag set without accepted page");
  a_devid_fixed: assert property ( // R18
    reg_rd && reg_addr == OFF_DEV_ID |=> reg_rdata == DEV_ID_VAL)
    else $error("device identifier changed");
  // the first edge after reset still holds reset copies, so it is skipped
  a_link_follow: assert property ( // R20
    !$past(sys_rst) |-> link_up[0] == $past(link_pulse_ok[0])
      && negotiation_done[0] == $past(an_finished[0]))
    else $error("link or done not following engine");
  a_probe_release: assert property ( // R5
    $fell(duplex_oe[0]) |-> $past(duplex_oe[0], 2) && !$past(duplex_out[0]))
    else $error("duplex probe sequence broken");

  c_page_then_read: cover property (page_hit[2] ##[1:20] (reg_rd && reg_addr == OFF_LPA));
  c_np_round: cover property (np_tx_req[1] ##[1:20] np_sent[1]);
  c_adv_write: cover property (reg_wr && reg_addr == OFF_ADV);
  c_strap_probe: cover property ($fell(duplex_oe[3]));
endmodule : pan_regs
`default_nettype wire

/* File: tb/pan_partner.sv */
// Purpose: engine-side model feeding code words, link state and the duplex pin
// Assumes: the bench sets link levels and pin straps through this instance
// Notes: a word is not held after its pulse; the duplex pin has a pull-up
`default_nettype none
module pan_partner (
  input wire logic sys_clk,
  input wire logic [pan_pkg::NUM_PHY-1:0] np_tx_req,
  input wire logic [pan_pkg::NUM_PHY-1:0] duplex_out,
  input wire logic [pan_pkg::NUM_PHY-1:0] duplex_oe,
  output logic [pan_pkg::NUM_PHY-1:0] cw_valid,
  output logic [pan_pkg::NUM_PHY-1:0][pan_pkg::DATA_W-1:0] cw_word,
  output logic [pan_pkg::NUM_PHY-1:0] flp_seen,
  output logic [pan_pkg::NUM_PHY-1:0] link_pulse_ok,
  output logic [pan_pkg::NUM_PHY-1:0] an_finished,
  output logic [pan_pkg::NUM_PHY-1:0] np_sent,
  output logic [pan_pkg::NUM_PHY-1:0] duplex_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import pan_pkg::*;
  logic [NUM_PHY-1:0] stuck_en = '0;
  logic [NUM_PHY-1:0] stuck_val = '0;
  int np_delay = 1;
  int wait_cnt [NUM_PHY];

  // ==========================================================
  // pin and lines
  // a strap beats the drive, so a strapped pin fails one probe direction
  assign duplex_in = (stuck_en & stuck_val) |
                     (~stuck_en & ((duplex_oe & duplex_out) | ~duplex_oe));

  // all lines quiet until the bench raises them
  initial begin
    {cw_valid, flp_seen, link_pulse_ok, an_finished, np_sent} = '0;
    cw_word = '0;
  end

  // one code word pulse; the word flips afterwards so nothing stale passes
  task automatic send_word(input int p, input logic [15:0] w);
    @(posedge sys_clk);
    #1;
    cw_valid[p] = 1'b1;
    cw_word[p] = w;
    @(posedge sys_clk);
    #1;
    cw_valid[p] = 1'b0;
    cw_word[p] = ~w;
  endtask : send_word

  // ==========================================================
  // next page sending
  // report a page sent np_delay + 1 cycles after each request
  always @(posedge sys_clk) begin
    #1;
    for (int p = 0; p < NUM_PHY; p++) begin
      np_sent[p] = (wait_cnt[p] == 1);
      if (np_tx_req[p] === 1'b1) begin
        wait_cnt[p] = np_delay + 1;
      end else if (wait_cnt[p] > 0) begin
        wait_cnt[p]--;
      end
    end
  end
endmodule : pan_partner
`default_nettype wire

/* File: tb/testbench.sv */
// Purpose: self-checking bench for the auto-negotiation register bank
// Assumes: partner model drives the engine side, bench drives management
// Notes: expected words come from the register map, never from outputs
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import pan_pkg::*;
  localparam logic [15:0] ID_HI = 16'h1111; // arbitrary value
  localparam logic [15:0] ID_LO = 16'h2222; // arbitrary value
  localparam logic [15:0] DEV_ID = 16'h0033; // arbitrary value
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [PHY_W-1:0] reg_phy = '0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic [DATA_W-1:0] reg_rdata;
  logic [NUM_PHY-1:0] cw_valid, flp_seen, link_pulse_ok, an_finished, np_sent;
  logic [NUM_PHY-1:0] np_tx_req, negotiation_done, link_up, duplex_in, duplex_out, duplex_oe;
  logic [NUM_PHY-1:0][DATA_W-1:0] cw_word, adv_word, np_tx_word;
  int fail_count = 0;
  int n_tests = 0;
  int cycles = 0;

  pan_regs #(.ID_HIGH_VAL(ID_HI), .ID_LOW_VAL(ID_LO), .DEV_ID_VAL(DEV_ID)) dut (
    .sys_clk, .sys_rst, .reg_wr, .reg_rd, .reg_phy, .reg_addr, .reg_wdata, .reg_rdata,
    .cw_valid, .cw_word, .flp_seen, .link_pulse_ok, .an_finished, .np_sent, .adv_word,
    .np_tx_word, .np_tx_req, .negotiation_done, .link_up, .duplex_in, .duplex_out,
    .duplex_oe);
  pan_partner partner (.sys_clk, .np_tx_req, .duplex_out, .duplex_oe, .cw_valid, .cw_word,
    .flp_seen, .link_pulse_ok, .an_finished, .np_sent, .duplex_in);

  // ==========================================================
  // clock, timeout and common tasks
  always #2 sys_clk = ~sys_clk;

  // a hang counts as a mismatch; the whole run needs well under 600 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic do_reset();
    sys_rst = 1'b1;
    repeat (10) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask : do_reset

  // one-cycle strobe; read data is then valid until the next read
  task automatic access(input logic w, input logic [1:0] p, input logic [4:0] a,
                        input logic [15:0] d);
    @(posedge sys_clk);
    #1;
    reg_wr = w;
    reg_rd = ~w;
    {reg_phy, reg_addr, reg_wdata} = {p, a, d};
    @(posedge sys_clk);
    #1;
    {reg_wr, reg_rd} = 2'b00;
  endtask : access

  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check16

  task automatic check_rd(input logic [1:0] p, input logic [4:0] a, input logic [15:0] exp);
    access(1'b0, p, a, 16'h0000);
    check16(reg_rdata, exp);
  endtask : check_rd

  // ==========================================================
  // scenarios
  task automatic test_ident();
    logic [4:0] offs [5] = '{OFF_ID_HI, OFF_ID_LO, OFF_LPA, OFF_EXP, OFF_DEV_ID};
    foreach (offs[i]) access(1'b1, 2'd0, offs[i], 16'hFFFF);
    check_rd(2'd0, OFF_ID_HI, ID_HI);
    check_rd(2'd0, OFF_ID_LO, ID_LO);
    check_rd(2'd0, OFF_DEV_ID, DEV_ID);
    check_rd(2'd0, OFF_EXP, 16'h0014);
    check_rd(2'd0, 5'h1F, 16'h0000);
    $display("test ident done");
  endtask : test_ident

  task automatic test_adv();
    check_rd(2'd0, OFF_ADV, 16'h0061);
    access(1'b1, 2'd0, OFF_ADV, 16'hFFFF);
    check_rd(2'd0, OFF_ADV, 16'h2061);
    check16(adv_word[0], 16'h2061);
    access(1'b1, 2'd0, OFF_ADV, 16'h0000);
    check_rd(2'd0, OFF_ADV, 16'h0001);
    check_rd(2'd1, OFF_ADV, 16'h0061);
    $display("test adv done");
  endtask : test_adv

  // page on PHY 2, then a broken run of words that must not count
  task automatic test_page();
    check_rd(2'd2, OFF_EXP, 16'h0014);
    repeat (3) partner.send_word(2, 16'hDC21);
    repeat (3) @(posedge sys_clk);
    check_rd(2'd2, OFF_EXP, 16'h001E);
    check_rd(2'd2, OFF_LPA, 16'hDC21);
    check_rd(2'd2, OFF_EXP, 16'h001C);
    check_rd(2'd2, OFF_LPA, 16'h8021);
    partner.send_word(2, 16'h0021);
    partner.send_word(2, 16'h0021);
    partner.send_word(2, 16'h0041);
    repeat (3) @(posedge sys_clk);
    check_rd(2'd2, OFF_EXP, 16'h001C);
    access(1'b1, 2'd2, OFF_LPA, 16'hFFFF);
    check_rd(2'd2, OFF_LPA, 16'h8021);
    $display("test page done");
  endtask : test_page

  task automatic test_link();
    @(posedge sys_clk);
    #1;
    partner.link_pulse_ok[0] = 1'b1;
    partner.flp_seen[0] = 1'b1;
    partner.an_finished[0] = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    check16(16'({link_up[0], negotiation_done[0]}), 16'h0003);
    check_rd(2'd0, OFF_EXP, 16'h0005);
    check_rd(2'd3, OFF_EXP, 16'h0014);
    partner.link_pulse_ok[0] = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    check16(16'(link_up), 16'h0000);
    check_rd(2'd0, OFF_EXP, 16'h0015);
    $display("test link done");
  endtask : test_link

  // slow partner keeps the page pending long enough to be seen
  task automatic test_np();
    partner.np_delay = 6;
    access(1'b1, 2'd1, OFF_NPT, 16'h2ABC);
    check16(16'(np_tx_req), 16'h0002);
    check16(np_tx_word[1], 16'h2ABC);
    @(posedge sys_clk);
    #1;
    check16(16'(np_tx_req), 16'h0000);
    check_rd(2'd1, OFF_ADV, 16'h8061);
    check_rd(2'd1, OFF_NPT, 16'h2ABC);
    repeat (8) @(posedge sys_clk);
    check_rd(2'd1, OFF_ADV, 16'h0061);
    $display("test np done");
  endtask : test_np

  // straps hold one pin high and one low through a second reset
  task automatic test_strap();
    partner.stuck_en[3:2] = 2'b11;
    partner.stuck_val[3:2] = 2'b10;
    do_reset();
    check_rd(2'd3, OFF_ADV, 16'h0041);
    check_rd(2'd2, OFF_ADV, 16'h0021);
    check_rd(2'd0, OFF_ADV, 16'h0061);
    $display("test strap done");
  endtask : test_strap

  // ==========================================================
  // main sequence
  initial begin
    do_reset();
    test_ident();
    test_adv();
    test_page();
    test_link();
    test_np();
    test_strap();
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
